//--- hdl/sbfa_defs.vh
`ifndef SBFA_DEFS_VH
`define SBFA_DEFS_VH

// Register byte offsets
`define SBFA_ADDR_W          8
`define SBFA_OFS_OPA_LO      8'h00
`define SBFA_OFS_OPA_HI      8'h04
`define SBFA_OFS_OPB_LO      8'h08
`define SBFA_OFS_OPB_HI      8'h0C
`define SBFA_OFS_CTRL        8'h10
`define SBFA_OFS_FLAGS       8'h14
`define SBFA_OFS_CMD         8'h18
`define SBFA_OFS_RES_LO      8'h1C
`define SBFA_OFS_RES_HI      8'h20
`define SBFA_OFS_STATUS      8'h24

// Control register fields
`define SBFA_CTRL_OP_LSB     0
`define SBFA_CTRL_OP_MSB     1
`define SBFA_CTRL_WIDE_BIT   2
`define SBFA_CTRL_N_BIT      3
`define SBFA_CTRL_IMMR_LSB   4
`define SBFA_CTRL_IMMR_MSB   9
`define SBFA_CTRL_IMMS_LSB   10
`define SBFA_CTRL_IMMS_MSB   15
`define SBFA_CTRL_DTG_BIT    16
`define SBFA_CTRL_W          17
`define SBFA_CTRL_RESET      17'h0_0000

// Operation codes
`define SBFA_OP_SUB          2'h0
`define SBFA_OP_SUB_FLAGS    2'h1
`define SBFA_OP_FIELD_MOVE   2'h2

// Flags register fields (N Z C V)
`define SBFA_FLAG_N_BIT      3
`define SBFA_FLAG_Z_BIT      2
`define SBFA_FLAG_C_BIT      1
`define SBFA_FLAG_V_BIT      0
`define SBFA_FLAGS_RESET     4'h0

// Command and status fields
`define SBFA_CMD_GO_BIT      0
`define SBFA_STAT_DONE_BIT   0
`define SBFA_STAT_UNDEF_BIT  1

// Fixed execution latency in cycles
`define SBFA_EXEC_CYCLES     1

`endif

//--- hdl/sbfa_field_unit.v
// Signed field move datapath: masks, rotate, sign fill
module sbfa_field_unit (
   src,
   immr,
   imms,
   wide,
   result
);
   input  wire [63:0] src;
   input  wire [5:0]  immr;
   input  wire [5:0]  imms;
   input  wire        wide;
   output wire [63:0] result;

   // Rotate right within the operand width
   function [63:0] ror_w;
      input [63:0] v;
      input [5:0]  amt;
      input        w;
      reg   [31:0] lo;
      reg   [4:0]  a5;
      begin
         lo = v[31:0];
         a5 = amt[4:0];
         if (w) begin
            ror_w = (v >> amt) | (v << (7'd64 - {1'b0, amt}));
         end else begin
            ror_w = {32'h0000_0000, (lo >> a5) | (lo << (6'd32 - {1'b0, a5}))};
         end
      end
   endfunction

   // Ones in bits n down to 0
   function [63:0] ones_to;
      input [5:0] n;
      begin
         ones_to = {64{1'b1}} >> (6'd63 - n);
      end
   endfunction

   wire [63:0] width_mask;
   wire [63:0] src_w;
   wire [5:0]  diff;
   wire [5:0]  diff_w;
   wire [5:0]  top_pos;
   wire [63:0] wmask;
   wire [63:0] tmask;
   wire [63:0] bot;
   wire [63:0] fill;

   assign width_mask = wide ? {64{1'b1}} : {32'h0000_0000, 32'hFFFF_FFFF};
   assign src_w      = src & width_mask;
   assign diff       = imms - immr;
   assign diff_w     = wide ? diff : {1'b0, diff[4:0]};
   assign top_pos    = wide ? imms : {1'b0, imms[4:0]};
   // Masks from field top and rotate, element size equals operand width
   assign wmask      = ror_w(ones_to(top_pos), immr, wide) & width_mask;
   assign tmask      = ones_to(diff_w) & width_mask;
   assign bot        = ror_w(src_w, immr, wide) & wmask;
   assign fill       = {64{src_w[top_pos]}};
   // Extract when top >= rotate, insert at width-rotate otherwise
   assign result     = ((fill & ~tmask) | (bot & tmask)) & width_mask;

endmodule // sbfa_field_unit

//--- hdl/sbfa_alu.v
`include "sbfa_defs.vh"

module sbfa_alu (
   SYS_CLK,
   RESET,
   PSEL,
   PENABLE,
   PWRITE,
   PADDR,
   PWDATA,
   PRDATA,
   PREADY,
   PSLVERR
);
   input  wire                      SYS_CLK;
   input  wire                      RESET;
   input  wire                      PSEL;
   input  wire                      PENABLE;
   input  wire                      PWRITE;
   input  wire [`SBFA_ADDR_W-1:0]   PADDR;
   input  wire [31:0]               PWDATA;
   output wire [31:0]               PRDATA;
   output wire                      PREADY;
   output wire                      PSLVERR;

   // Address decode for the error path; the read path decodes with its own case
   function mapped;
      input [`SBFA_ADDR_W-1:0] a;
      begin
         case (a)
            `SBFA_OFS_OPA_LO,
            `SBFA_OFS_OPA_HI,
            `SBFA_OFS_OPB_LO,
            `SBFA_OFS_OPB_HI,
            `SBFA_OFS_CTRL,
            `SBFA_OFS_FLAGS,
            `SBFA_OFS_CMD,
            `SBFA_OFS_RES_LO,
            `SBFA_OFS_RES_HI,
            `SBFA_OFS_STATUS: mapped = 1'b1;
            default:          mapped = 1'b0;
         endcase
      end
   endfunction

   // Carry addition at the operand width, packed as {n, z, c, v, result}
   function [67:0] add_carry;
      input [63:0] a;
      input [63:0] b;
      input        cin;
      input        w;
      reg   [64:0] s64;
      reg   [32:0] s32;
      reg   [63:0] r;
      reg          n;
      reg          z;
      reg          c;
      reg          v;
      begin
         s64 = {1'b0, a} + {1'b0, b} + {64'h0000_0000_0000_0000, cin};
         s32 = {1'b0, a[31:0]} + {1'b0, b[31:0]} + {32'h0000_0000, cin};
         if (w) begin
            r = s64[63:0];
            n = s64[63];
            c = s64[64];
            v = (a[63] == b[63]) & (s64[63] != a[63]);
         end else begin
            r = {32'h0000_0000, s32[31:0]};
            n = s32[31];
            c = s32[32];
            v = (a[31] == b[31]) & (s32[31] != a[31]);
         end
         z = (r == 64'h0000_0000_0000_0000);
         add_carry = {n, z, c, v, r};
      end
   endfunction

   // One busy cycle per operation
   localparam ST_IDLE = 1'b0;
   localparam ST_EXEC = 1'b1;

   // Programmer-visible registers and bus latches
   reg  [63:0]              opa_reg;
   reg  [63:0]              opa_next;
   reg  [63:0]              opb_reg;
   reg  [63:0]              opb_next;
   reg  [`SBFA_CTRL_W-1:0]  ctrl_reg;
   reg  [`SBFA_CTRL_W-1:0]  ctrl_next;
   reg  [3:0]               flags_reg;
   reg  [3:0]               flags_next;
   reg  [63:0]              res_reg;
   reg  [63:0]              res_next;
   reg                      done_reg;
   reg                      done_next;
   reg                      undef_reg;
   reg                      undef_next;
   reg                      state_reg;
   reg                      state_next;
   reg  [31:0]              prdata_reg;
   reg  [31:0]              prdata_next;
   reg                      pslverr_reg;
   reg                      pslverr_next;

   // Datapath nets
   wire                     setup_phase;
   wire                     wr_access;
   wire                     go;
   wire [1:0]               op;
   wire                     wide;
   wire                     field_n;
   wire [5:0]               immr;
   wire [5:0]               imms;
   wire                     carry_flag;
   wire [63:0]              width_mask;
   wire [63:0]              src1;
   wire [63:0]              src2_inv;
   wire [67:0]              sub_pack;
   wire [63:0]              sub_res;
   wire                     sub_n;
   wire                     sub_z;
   wire                     sub_c;
   wire                     sub_v;
   wire                     field_undef;
   wire [63:0]              field_res;

   // Bus phase decode
   assign setup_phase = PSEL & ~PENABLE;
   assign wr_access   = PSEL & PENABLE & PWRITE;
   assign go          = wr_access & (PADDR == `SBFA_OFS_CMD) & PWDATA[`SBFA_CMD_GO_BIT];

   // Decoded control fields
   assign op          = ctrl_reg[`SBFA_CTRL_OP_MSB:`SBFA_CTRL_OP_LSB];
   assign wide        = ctrl_reg[`SBFA_CTRL_WIDE_BIT];
   assign field_n     = ctrl_reg[`SBFA_CTRL_N_BIT];
   assign immr        = ctrl_reg[`SBFA_CTRL_IMMR_MSB:`SBFA_CTRL_IMMR_LSB];
   assign imms        = ctrl_reg[`SBFA_CTRL_IMMS_MSB:`SBFA_CTRL_IMMS_LSB];
   assign carry_flag  = flags_reg[`SBFA_FLAG_C_BIT];

   // Narrow form ignores upper source halves and zeroes upper result
   assign width_mask  = wide ? {64{1'b1}} : {32'h0000_0000, 32'hFFFF_FFFF};
   assign src1        = opa_reg & width_mask;
   assign src2_inv    = ~opb_reg & width_mask;

   // Carry addition at the selected width
   assign sub_pack    = add_carry(src1, src2_inv, carry_flag, wide);
   assign sub_res     = sub_pack[63:0];
   assign sub_n       = sub_pack[67];
   assign sub_z       = sub_pack[66];
   assign sub_c       = sub_pack[65];
   assign sub_v       = sub_pack[64];

   // Reserved field-move encodings
   assign field_undef = wide ? ~field_n
                             : (field_n | immr[5] | imms[5]);

   // Insert-in-zeros needs no extra path: software encodes it via immr and imms
   sbfa_field_unit u_field (
      .src    (opa_reg),
      .immr   (immr),
      .imms   (imms),
      .wide   (wide),
      .result (field_res)
   );

   // Execution is one fixed cycle for every operand and flag value
   always @* begin
      state_next = state_reg;
      res_next   = res_reg;
      flags_next = flags_reg;
      undef_next = undef_reg;
      done_next  = done_reg;
      opa_next   = opa_reg;
      opb_next   = opb_reg;
      ctrl_next  = ctrl_reg;
      case (state_reg)
         ST_IDLE: begin
            if (go) begin
               state_next = ST_EXEC;
               done_next  = 1'b0;
            end
         end
         // Busy cycle: result, flags and status land at its end
         ST_EXEC: begin
            state_next = ST_IDLE;
            done_next  = 1'b1;
            undef_next = 1'b0;
            case (op)
               `SBFA_OP_SUB: begin
                  res_next = sub_res;
               end
               `SBFA_OP_SUB_FLAGS: begin
                  res_next   = sub_res;
                  flags_next = {sub_n, sub_z, sub_c, sub_v};
               end
               `SBFA_OP_FIELD_MOVE: begin
                  if (field_undef) begin
                     undef_next = 1'b1;
                  end else begin
                     res_next = field_res;
                  end
               end
               default: begin
                  undef_next = 1'b1;
               end
            endcase
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase

      // Register writes; ignored while an operation executes
      if (wr_access && state_reg == ST_IDLE) begin
         case (PADDR)
            `SBFA_OFS_OPA_LO: opa_next[31:0]  = PWDATA;
            `SBFA_OFS_OPA_HI: opa_next[63:32] = PWDATA;
            `SBFA_OFS_OPB_LO: opb_next[31:0]  = PWDATA;
            `SBFA_OFS_OPB_HI: opb_next[63:32] = PWDATA;
            `SBFA_OFS_CTRL:   ctrl_next       = PWDATA[`SBFA_CTRL_W-1:0];
            `SBFA_OFS_FLAGS:  flags_next      = PWDATA[3:0];
            `SBFA_OFS_STATUS: begin
               if (PWDATA[`SBFA_STAT_DONE_BIT] && !go) begin
                  done_next = 1'b0;
               end
            end
            default: begin
               opa_next = opa_reg;
            end
         endcase
      end
   end

   // Read data and error latched in the setup cycle
   always @* begin
      prdata_next  = prdata_reg;
      pslverr_next = pslverr_reg;
      if (setup_phase) begin
         pslverr_next = ~mapped(PADDR);
         case (PADDR)
            `SBFA_OFS_OPA_LO: prdata_next = opa_reg[31:0];
            `SBFA_OFS_OPA_HI: prdata_next = opa_reg[63:32];
            `SBFA_OFS_OPB_LO: prdata_next = opb_reg[31:0];
            `SBFA_OFS_OPB_HI: prdata_next = opb_reg[63:32];
            `SBFA_OFS_CTRL:   prdata_next = {15'h0000, ctrl_reg};
            `SBFA_OFS_FLAGS:  prdata_next = {28'h000_0000, flags_reg};
            `SBFA_OFS_CMD:    prdata_next = 32'h0000_0000;
            `SBFA_OFS_RES_LO: prdata_next = res_reg[31:0];
            `SBFA_OFS_RES_HI: prdata_next = res_reg[63:32];
            `SBFA_OFS_STATUS: prdata_next = {29'h0000_0000, state_reg, undef_reg, done_reg};
            default:          prdata_next = 32'h0000_0000;
         endcase
      end
   end

   // Synchronous reset clears every register
   always @(posedge SYS_CLK) begin
      if (RESET) begin
         opa_reg     <= 64'h0000_0000_0000_0000;
         opb_reg     <= 64'h0000_0000_0000_0000;
         ctrl_reg    <= `SBFA_CTRL_RESET;
         flags_reg   <= `SBFA_FLAGS_RESET;
         res_reg     <= 64'h0000_0000_0000_0000;
         done_reg    <= 1'b0;
         undef_reg   <= 1'b0;
         state_reg   <= ST_IDLE;
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else begin
         opa_reg     <= opa_next;
         opb_reg     <= opb_next;
         ctrl_reg    <= ctrl_next;
         flags_reg   <= flags_next;
         res_reg     <= res_next;
         done_reg    <= done_next;
         undef_reg   <= undef_next;
         state_reg   <= state_next;
         prdata_reg  <= prdata_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // Zero wait states; error shown only in the access phase
   assign PREADY  = 1'b1;
   assign PRDATA  = prdata_reg;
   assign PSLVERR = pslverr_reg & PSEL & PENABLE;

endmodule // sbfa_alu

//--- tb/sbfa_alu_checker.sv
`include "sbfa_defs.vh"

module sbfa_alu_checker (
   input wire logic        SYS_CLK,
   input wire logic        RESET,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   logic acc;
   logic rd;
   assign acc = PSEL && PENABLE;
   assign rd  = acc && !PWRITE;
   property p_ready; acc |-> PREADY; endproperty
   a_ready: assert property (p_ready) else $error("ready low in access phase");
   property p_err_place; PSLVERR |-> acc; endproperty
   a_err_place: assert property (p_err_place) else $error("error outside access phase");
   property p_err_unmapped; acc && PADDR > 8'h24 |-> PSLVERR; endproperty
   a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not flagged");
   property p_ctrl_width; rd && PADDR == `SBFA_OFS_CTRL |-> PRDATA[31:17] == 15'h0000; endproperty
   a_ctrl_width: assert property (p_ctrl_width) else $error("control upper bits set");
   property p_flags_width; rd && PADDR == `SBFA_OFS_FLAGS |-> PRDATA[31:4] == 28'h000_0000; endproperty
   a_flags_width: assert property (p_flags_width) else $error("flags upper bits set");
   property p_cmd_zero; rd && PADDR == `SBFA_OFS_CMD |-> PRDATA == 32'h0000_0000; endproperty
   a_cmd_zero: assert property (p_cmd_zero) else $error("command reads nonzero");
   property p_idle_hold; !PSEL && !$past(PSEL) |-> $stable(PRDATA); endproperty
   a_idle_hold: assert property (p_idle_hold) else $error("read data moved while idle");
   property p_reset_zero; $fell(RESET) |-> PRDATA == 32'h0000_0000 && !PSLVERR; endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("outputs not cleared by reset");
   property p_done;
      acc && PWRITE && PADDR == `SBFA_OFS_CMD && PWDATA[0] ##[2:3] rd && PADDR == `SBFA_OFS_STATUS |-> PRDATA[0];
   endproperty
   a_done: assert property (p_done) else $error("operation not done after one cycle");
endmodule // sbfa_alu_checker

bind sbfa_alu sbfa_alu_checker sbfa_alu_checker_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR));

//--- tb/tb_subtract_carry_bitfield_alu.sv
`include "sbfa_defs.vh"

module tb_subtract_carry_bitfield_alu;
   timeunit 1ns;
   timeprecision 1ns;
   logic        SYS_CLK = 1'b0;
   logic        RESET = 1'b1;
   logic        PSEL = 1'b0;
   logic        PENABLE = 1'b0;
   logic        PWRITE = 1'b0;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0000_0000;
   wire  [31:0] PRDATA;
   wire         PREADY;
   wire         PSLVERR;
   int          fail_count = 0;
   int          total_checks = 0;
   logic [63:0] last_res = 64'h0000_0000_0000_0000;
   logic [31:0] q;
   logic        e;

   always #20 SYS_CLK = ~SYS_CLK;

   sbfa_alu sbfa_alu_inst (.SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR));

   task automatic chk(input string n, input [63:0] x, input [63:0] g);
      total_checks++;
      if (g !== x) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", n, x, g);
      end
   endtask

   task automatic xfer(input w, input [7:0] a, input [31:0] d);
      @(posedge SYS_CLK);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge SYS_CLK);
      PENABLE <= 1'b1;
      do @(posedge SYS_CLK); while (PREADY !== 1'b1);
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask

   task automatic rdchk(input string n, input [7:0] a, input [31:0] x);
      xfer(1'b0, a, 32'h0000_0000);
      chk(n, {32'h0000_0000, x}, {32'h0000_0000, q});
      chk({n, "_err"}, 64'h0000_0000_0000_0000, {63'h0, e});
   endtask

   task automatic run(input [63:0] a, b, input [3:0] f, input [16:0] c, input [63:0] er, input [3:0] ef,
                      input u);
      xfer(1'b1, `SBFA_OFS_OPA_LO, a[31:0]);
      xfer(1'b1, `SBFA_OFS_OPA_HI, a[63:32]);
      xfer(1'b1, `SBFA_OFS_OPB_LO, b[31:0]);
      xfer(1'b1, `SBFA_OFS_OPB_HI, b[63:32]);
      xfer(1'b1, `SBFA_OFS_FLAGS, {28'h000_0000, f});
      xfer(1'b1, `SBFA_OFS_CTRL, {15'h0000, c});
      xfer(1'b1, `SBFA_OFS_CMD, 32'h0000_0001);
      rdchk("status", `SBFA_OFS_STATUS, {30'h0000_0000, u, 1'b1});
      rdchk("res_lo", `SBFA_OFS_RES_LO, er[31:0]);
      rdchk("res_hi", `SBFA_OFS_RES_HI, er[63:32]);
      rdchk("flags", `SBFA_OFS_FLAGS, {28'h000_0000, ef});
      if (!u) last_res = er;
   endtask

   task automatic sub(input [63:0] a, b, input [3:0] f, input op, w, dtg);
      int          k;
      logic [63:0] m, x, y, r;
      logic [64:0] s;
      logic [3:0]  ef;
      k = w ? 64 : 32;
      m = w ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h0000_0000_FFFF_FFFF;
      x = a & m;
      y = ~b & m;
      s = {1'b0, x} + {1'b0, y} + f[1];
      r = s[63:0] & m;
      ef = {r[k-1], r == 64'h0000_0000_0000_0000, w ? s[64] : s[32], x[k-1] == y[k-1] && r[k-1] != x[k-1]};
      run(a, b, f, {dtg, 12'h000, 1'b0, w, 1'b0, op}, r, op ? ef : f, 1'b0);
   endtask

   task automatic fld(input [63:0] v, input w, n, input [5:0] r, s);
      int          k, p, len, base;
      logic [63:0] o;
      logic        u;
      k = w ? 64 : 32;
      u = w ? !n : (n || r[5] || s[5]);
      o = 64'h0000_0000_0000_0000;
      p = s >= r ? 0 : k - r;
      len = s >= r ? s - r + 1 : s + 1;
      base = s >= r ? r : 0;
      for (int i = 0; i < k; i++) o[i] = i < p ? 1'b0 : (i < p + len ? v[i - p + base] : v[s]);
      run(v, 64'h0000_0000_0000_0000, 4'h5, {1'b0, s, r, n, w, 2'h2}, u ? last_res : o, 4'h5, u);
   endtask

   task automatic t_sub;
      sub(64'h0000_0000_0000_0005, 64'h0000_0000_0000_0003, 4'h2, 1'b1, 1'b1, 1'b1);
      sub(64'h0000_0000_0000_0005, 64'h0000_0000_0000_0007, 4'h0, 1'b1, 1'b1, 1'b0);
      sub(64'h8000_0000_0000_0000, 64'h0000_0000_0000_0001, 4'h2, 1'b1, 1'b1, 1'b0);
      sub(64'h0000_0000_0000_0003, 64'h0000_0000_0000_0003, 4'h2, 1'b1, 1'b1, 1'b0);
      sub(64'hFFFF_FFFF_0000_0000, 64'h1234_5678_0000_0000, 4'h0, 1'b1, 1'b0, 1'b0);
      sub(64'h0000_0000_8000_0000, 64'h0000_0000_0000_0001, 4'h2, 1'b1, 1'b0, 1'b0);
      sub(64'h0000_0000_0000_0003, 64'h0000_0000_0000_0003, 4'hA, 1'b0, 1'b1, 1'b0);
      sub(64'h0000_0000_0000_0003, 64'h0000_0000_0000_0003, 4'hD, 1'b0, 1'b0, 1'b0);
      $display("test subtract done");
   endtask

   task automatic t_field;
      fld(64'h0000_0000_0000_8A00, 1'b1, 1'b1, 6'h08, 6'h0F);
      fld(64'hFFFF_FFFF_0000_0AB0, 1'b0, 1'b0, 6'h04, 6'h0B);
      fld(64'h0000_0000_0000_00C5, 1'b1, 1'b1, 6'h38, 6'h07);
      fld(64'h0000_0000_0000_0005, 1'b0, 1'b0, 6'h04, 6'h03);
      fld(64'h0000_0000_0000_0080, 1'b1, 1'b1, 6'h00, 6'h07);
      fld(64'h1234_5678_9ABC_DEF0, 1'b1, 1'b1, 6'h00, 6'h3F);
      fld(64'h0000_0000_0000_0001, 1'b1, 1'b1, 6'h3F, 6'h00);
      fld(64'h0000_0000_0000_00FF, 1'b1, 1'b0, 6'h00, 6'h07);
      fld(64'h0000_0000_0000_00FF, 1'b0, 1'b1, 6'h00, 6'h07);
      fld(64'h0000_0000_0000_00FF, 1'b0, 1'b0, 6'h20, 6'h07);
      fld(64'h0000_0000_0000_00FF, 1'b0, 1'b0, 6'h00, 6'h27);
      run(64'h0000_0000_0000_0001, 64'h0000_0000_0000_0001, 4'h9, 17'h0_0003, last_res, 4'h9, 1'b1);
      xfer(1'b1, `SBFA_OFS_STATUS, 32'h0000_0001);
      rdchk("done_clear", `SBFA_OFS_STATUS, 32'h0000_0002);
      $display("test field move done");
   endtask

   task automatic t_bus;
      rdchk("ctrl_reset", `SBFA_OFS_CTRL, 32'h0000_0000);
      xfer(1'b0, 8'h40, 32'h0000_0000);
      chk("slverr", 64'h0000_0000_0000_0001, {63'h0, e});
      chk("unmapped", 64'h0000_0000_0000_0000, {32'h0000_0000, q});
      rdchk("cmd", `SBFA_OFS_CMD, 32'h0000_0000);
      xfer(1'b1, `SBFA_OFS_RES_LO, 32'hFFFF_FFFF);
      rdchk("res_ro", `SBFA_OFS_RES_LO, last_res[31:0]);
      $display("test bus done");
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge SYS_CLK);
      RESET <= 1'b0;
      t_bus;
      t_sub;
      t_field;
      complete_run;
   end

   initial begin
      repeat (5000) @(posedge SYS_CLK);
      fail_count++;
      complete_run;
   end
endmodule // tb_subtract_carry_bitfield_alu
